// ===== rtl/branch_sysctl_block_move_exec.sv
// Branch, system-control and block-move instruction executor
// Contract
// RULE1: Conditional branch jumps only when condition true
// RULE2: Decode all sixteen branch conditions
// RULE3: Absolute jump ignores flags
// RULE4: Calls save return point; return resumes there
// RULE5: Software trap starts trap exception handling
// RULE6: Exception return resumes interrupted program
// RULE7: Sleep enters power-down state
// RULE8: Flags load from memory uses word read
// RULE9: Flags store to memory uses word write
// RULE10: Flag AND/OR/XOR with immediate byte
// RULE11: No-operation only advances program counter by two
// RULE12: Byte-count move copies bytes until count zero
// RULE13: Word-count move uses full sixteen-bit count
// RULE14: Next instruction waits for move completion
// RULE15: Instructions are whole two-byte units
// RULE16: Operation field in first four bits
// RULE17: Three-bit address, three/four-bit data register fields
// RULE18: Extensions 8/16/32 bits; 24-bit zero-topped
// RULE19: Branch condition from dedicated condition field
// RULE20: Bit ops read, modify, write back byte
// RULE21: Software may clear known-set flags blindly
// RULE22: Branch uses current flag register values
module branch_sysctl_block_move_exec (
  input  wire logic         clock,           // System clock
  input  wire logic         sys_rst,         // Async reset
  input  wire logic [7:0]   avs_address,     // Register byte address
  input  wire logic         avs_read,        // Register read
  input  wire logic         avs_write,       // Register write
  input  wire logic [31:0]  avs_writedata,   // Register write data
  output logic [31:0]       avs_readdata,    // Register read data
  output logic              avs_waitrequest, // Register stall
  output exec_pkg::mem_req_t mem_req,        // Memory request
  input  wire logic [15:0]  mem_rdata,       // Memory read data
  input  wire logic         mem_ack,         // Memory access done
  input  wire logic         wake,            // Leave power-down
  output logic              sleeping         // In power-down
);
  exec_pkg::state_t state;
  exec_pkg::state_t next_state;
  exec_pkg::state_t ret;
  logic [23:0] pc;
  logic [23:0] next_pc;
  logic [7:0]  condition_code_reg;
  logic [7:0]  next_ccr;
  logic [15:0] ir;
  logic [15:0] next_ir;
  logic [31:0] ext;
  logic [31:0] next_ext;
  logic [31:0] tmp;
  logic [31:0] next_tmp;
  logic [31:0] er [8];
  logic [31:0] next_er [8];
  logic        run;
  logic        next_run;
  logic        illegal;
  logic        next_illegal;
  logic        bus_done;
  logic        next_bus_done;
  logic [31:0] next_readdata;
  logic        wr_fire;
  logic [15:0] count;
  logic [23:0] sp_addr;
  logic [23:0] reg_addr;

  function automatic logic cond_true(input logic [3:0] cc,
                                     input logic [7:0] f);
    logic c;
    logic v;
    logic z;
    logic n;
    c = f[exec_pkg::CCR_C];
    v = f[exec_pkg::CCR_V];
    z = f[exec_pkg::CCR_Z];
    n = f[exec_pkg::CCR_N];
    unique case (cc) // RULE2
      4'h0: cond_true = 1'b1;
      4'h1: cond_true = 1'b0;
      4'h2: cond_true = ~(c | z);
      4'h3: cond_true = c | z;
      4'h4: cond_true = ~c;
      4'h5: cond_true = c;
      4'h6: cond_true = ~z;
      4'h7: cond_true = z;
      4'h8: cond_true = ~v;
      4'h9: cond_true = v;
      4'hA: cond_true = ~n;
      4'hB: cond_true = n;
      4'hC: cond_true = ~(n ^ v);
      4'hD: cond_true = n ^ v;
      4'hE: cond_true = ~(z | (n ^ v));
      4'hF: cond_true = z | (n ^ v);
    endcase
  endfunction

  // Extension words after the opcode word
  function automatic logic [1:0] ext_words(input logic [15:0] w);
    logic [3:0] op;
    logic [3:0] sub;
    op = exec_pkg::op_field(w);
    sub = exec_pkg::sub_field(w);
    if (op == exec_pkg::OP_BCC16)
      ext_words = 2'h1;
    else if (op == exec_pkg::OP_SYS && (sub == exec_pkg::SUB_JMP_ABS ||
             sub == exec_pkg::SUB_JSR))
      ext_words = 2'h2;
    else
      ext_words = 2'h0;
  endfunction

  // Byte view of a data register: bit 3 picks low byte
  function automatic logic [7:0] get8(input logic [31:0] r,
                                      input logic sel_low);
    get8 = sel_low ? r[7:0] : r[15:8];
  endfunction

  function automatic logic [7:0] bit_mod(input logic [7:0] b,
                                         input logic [3:0] sub,
                                         input logic [2:0] n,
                                         input logic c);
    bit_mod = b;
    unique case (sub)
      exec_pkg::SUB_BIT_SET_OP: bit_mod[n] = 1'b1;
      exec_pkg::SUB_BIT_CLEAR_OP: bit_mod[n] = 1'b0;
      exec_pkg::SUB_BIT_INVERT_OP: bit_mod[n] = ~b[n];
      exec_pkg::SUB_BST:  bit_mod[n] = c;
      default:            bit_mod[n] = ~c;
    endcase
  endfunction

  assign wr_fire = avs_write & bus_done;
  assign avs_waitrequest = (avs_read | avs_write) & ~bus_done;
  assign sleeping = (state == exec_pkg::S_SLEEP);
  assign sp_addr = er[exec_pkg::SP_IDX][23:0];
  assign reg_addr = er[exec_pkg::reg_field(ir)][23:0];
  assign count = ir[exec_pkg::MOVE_WIDE] ?
                 er[exec_pkg::COUNT_IDX][15:0] :
                 {8'h00, er[exec_pkg::COUNT_IDX][7:0]};

  // Register slave: one wait state, read data from a flop
  always_comb begin
    next_bus_done = (avs_read | avs_write) & ~bus_done;
    next_readdata = avs_readdata;
    if (avs_read & ~bus_done) begin
      next_readdata = 32'h00000000;
      if (avs_address == exec_pkg::OFS_CTRL) begin
        next_readdata[exec_pkg::CTRL_RUN] = run;
        next_readdata[exec_pkg::CTRL_SLEEP] = sleeping;
        next_readdata[exec_pkg::CTRL_ILLEGAL] = illegal;
      end else if (avs_address == exec_pkg::OFS_PC)
        next_readdata = {8'h00, pc};
      else if (avs_address == exec_pkg::OFS_CCR)
        next_readdata = {24'h000000, condition_code_reg};
      else if (avs_address == exec_pkg::OFS_IR)
        next_readdata = {16'h0000, ir};
      else if (avs_address[7:5] == exec_pkg::OFS_ER_PAGE &&
               avs_address[1:0] == 2'h0)
        next_readdata = er[avs_address[4:2]];
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bus_done <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      bus_done <= next_bus_done;
      avs_readdata <= next_readdata;
    end
  end

  // Memory request follows the sequencer state
  always_comb begin
    mem_req = '0;
    unique case (state)
      exec_pkg::S_FETCH, exec_pkg::S_EXT_HI, exec_pkg::S_EXT_LO: begin
        mem_req.rd = 1'b1; // RULE15
        mem_req.word = 1'b1;
        mem_req.addr = pc;
      end
      exec_pkg::S_PUSH_HI, exec_pkg::S_PUSH_LO: begin
        mem_req.wr = 1'b1;
        mem_req.word = 1'b1;
        mem_req.addr = (state == exec_pkg::S_PUSH_HI) ? sp_addr :
                       sp_addr + exec_pkg::HALF_STEP;
        mem_req.wdata = (state == exec_pkg::S_PUSH_HI) ? tmp[31:16] :
                        tmp[15:0];
      end
      exec_pkg::S_POP_HI, exec_pkg::S_POP_LO: begin
        mem_req.rd = 1'b1;
        mem_req.word = 1'b1;
        mem_req.addr = (state == exec_pkg::S_POP_HI) ? sp_addr :
                       sp_addr + exec_pkg::HALF_STEP;
      end
      exec_pkg::S_VEC_HI, exec_pkg::S_VEC_LO: begin
        mem_req.rd = 1'b1;
        mem_req.word = 1'b1;
        mem_req.addr = (state == exec_pkg::S_VEC_HI) ? ext[23:0] :
                       ext[23:0] + exec_pkg::HALF_STEP;
      end
      exec_pkg::S_CCR_RD: begin
        mem_req.rd = 1'b1; // RULE8
        mem_req.word = 1'b1;
        mem_req.addr = reg_addr;
      end
      exec_pkg::S_CCR_WR: begin
        mem_req.wr = 1'b1; // RULE9
        mem_req.word = 1'b1;
        mem_req.addr = reg_addr;
        mem_req.wdata = {condition_code_reg, 8'h00};
      end
      exec_pkg::S_MOVE_RD: begin
        mem_req.rd = 1'b1; // RULE12
        mem_req.addr = er[exec_pkg::SRC_IDX][23:0];
      end
      exec_pkg::S_MOVE_WR: begin
        mem_req.wr = 1'b1;
        mem_req.addr = er[exec_pkg::DST_IDX][23:0];
        mem_req.wdata = {8'h00, tmp[7:0]};
      end
      exec_pkg::S_BIT_RD, exec_pkg::S_BIT_WR: begin
        mem_req.rd = (state == exec_pkg::S_BIT_RD); // RULE20
        mem_req.wr = (state == exec_pkg::S_BIT_WR);
        mem_req.addr = reg_addr;
        mem_req.wdata = {8'h00, tmp[7:0]};
      end
      default: mem_req = '0;
    endcase
    if (mem_req.word)
      mem_req.addr = mem_req.addr & exec_pkg::EVEN_MASK;
  end

  // Sequencer and architectural state
  always_comb begin
    next_state = state;
    next_pc = pc;
    next_ccr = condition_code_reg;
    next_ir = ir;
    next_ext = ext;
    next_tmp = tmp;
    next_er = er;
    next_run = run;
    next_illegal = illegal;
    ret = run ? exec_pkg::S_FETCH : exec_pkg::S_HALT;
    if (wr_fire) begin
      if (avs_address == exec_pkg::OFS_CTRL) begin
        next_run = avs_writedata[exec_pkg::CTRL_RUN];
        if (avs_writedata[exec_pkg::CTRL_ILLEGAL])
          next_illegal = 1'b0;
      end else if (state == exec_pkg::S_HALT) begin
        if (avs_address == exec_pkg::OFS_PC)
          next_pc = avs_writedata[23:0] & exec_pkg::EVEN_MASK;
        else if (avs_address == exec_pkg::OFS_CCR)
          next_ccr = avs_writedata[7:0];
        else if (avs_address[7:5] == exec_pkg::OFS_ER_PAGE &&
                 avs_address[1:0] == 2'h0)
          next_er[avs_address[4:2]] = avs_writedata;
      end
    end
    unique case (state)
      exec_pkg::S_HALT:
        if (run) next_state = exec_pkg::S_FETCH;
      exec_pkg::S_FETCH:
        if (mem_ack) begin
          next_ir = mem_rdata;
          next_pc = pc + exec_pkg::INSTR_STEP; // RULE15
          unique case (ext_words(mem_rdata)) // RULE18
            2'h2:    next_state = exec_pkg::S_EXT_HI;
            2'h1:    next_state = exec_pkg::S_EXT_LO;
            default: next_state = exec_pkg::S_EXEC;
          endcase
        end
      exec_pkg::S_EXT_HI:
        if (mem_ack) begin
          next_ext[31:16] = {8'h00, mem_rdata[7:0]}; // RULE18
          next_pc = pc + exec_pkg::INSTR_STEP;
          next_state = exec_pkg::S_EXT_LO;
        end
      exec_pkg::S_EXT_LO:
        if (mem_ack) begin
          if (exec_pkg::op_field(ir) == exec_pkg::OP_BCC16)
            next_ext = {{16{mem_rdata[15]}}, mem_rdata}; // RULE18
          else
            next_ext[15:0] = mem_rdata;
          next_pc = pc + exec_pkg::INSTR_STEP;
          next_state = exec_pkg::S_EXEC;
        end
      exec_pkg::S_EXEC: begin
        next_state = ret;
        unique case (exec_pkg::op_field(ir)) // RULE16
          exec_pkg::OP_BCC8, exec_pkg::OP_BCC16:
            if (cond_true(ir[11:8], condition_code_reg)) // RULE19 RULE22
              next_pc = (pc + ((exec_pkg::op_field(ir) ==
                         exec_pkg::OP_BCC8) ? exec_pkg::sext8(ir[7:0])
                         : ext[23:0])) & exec_pkg::EVEN_MASK; // RULE1
          exec_pkg::OP_SYS:
            unique case (exec_pkg::sub_field(ir)) // RULE16
              exec_pkg::SUB_JMP_ABS:
                next_pc = ext[23:0] & exec_pkg::EVEN_MASK; // RULE3
              exec_pkg::SUB_JMP_REG:
                next_pc = reg_addr & exec_pkg::EVEN_MASK; // RULE3 RULE17
              exec_pkg::SUB_BSR, exec_pkg::SUB_JSR,
              exec_pkg::SUB_TRAP: begin
                next_er[exec_pkg::SP_IDX] = er[exec_pkg::SP_IDX] -
                                            exec_pkg::LONG_STEP; // RULE4
                next_tmp = {8'h00, pc};
                next_state = exec_pkg::S_PUSH_HI;
                if (exec_pkg::sub_field(ir) == exec_pkg::SUB_BSR)
                  next_ext = {8'h00, pc + exec_pkg::sext8(ir[7:0])};
                if (exec_pkg::sub_field(ir) == exec_pkg::SUB_TRAP) begin
                  next_tmp = {condition_code_reg, pc}; // RULE5
                  next_ext = {8'h00, exec_pkg::TRAP_VEC_BASE +
                    {20'h00000, exec_pkg::trap_field(ir), 2'h0}};
                end
              end
              exec_pkg::SUB_RTS, exec_pkg::SUB_RTE:
                next_state = exec_pkg::S_POP_HI; // RULE4 RULE6
              exec_pkg::SUB_SLEEP:
                next_state = exec_pkg::S_SLEEP; // RULE7
              exec_pkg::SUB_NOP:
                next_state = ret; // RULE11
              exec_pkg::SUB_LDC_IMM:
                next_ccr = ir[7:0];
              exec_pkg::SUB_LDC_MEM:
                next_state = exec_pkg::S_CCR_RD; // RULE8
              exec_pkg::SUB_STC_MEM:
                next_state = exec_pkg::S_CCR_WR; // RULE9
              exec_pkg::SUB_FLAGS_AND_IMM:
                next_ccr = condition_code_reg & ir[7:0]; // RULE10
              exec_pkg::SUB_ORC:
                next_ccr = condition_code_reg | ir[7:0]; // RULE10
              exec_pkg::SUB_FLAGS_XOR_IMM:
                next_ccr = condition_code_reg ^ ir[7:0]; // RULE10
              exec_pkg::SUB_MOVE:
                if (count != 16'h0000) // RULE12 RULE13
                  next_state = exec_pkg::S_MOVE_RD;
            endcase
          exec_pkg::OP_REG8:
            if (exec_pkg::sub_field(ir) == exec_pkg::SUB_LDC_REG)
              next_ccr = get8(er[exec_pkg::reg8_field(ir)[2:0]],
                              exec_pkg::reg8_field(ir)[3]); // RULE17
            else if (exec_pkg::sub_field(ir) == exec_pkg::SUB_STC_REG) begin
              if (exec_pkg::reg8_field(ir)[3])
                next_er[exec_pkg::reg8_field(ir)[2:0]][7:0] = condition_code_reg;
              else
                next_er[exec_pkg::reg8_field(ir)[2:0]][15:8] = condition_code_reg;
            end else
              next_illegal = 1'b1;
          exec_pkg::OP_BIT:
            if (exec_pkg::sub_field(ir) <= exec_pkg::SUB_BIT_STORE_INV_CARRY_OP)
              next_state = exec_pkg::S_BIT_RD; // RULE20
            else
              next_illegal = 1'b1;
          default:
            next_illegal = 1'b1;
        endcase
      end
      exec_pkg::S_PUSH_HI:
        if (mem_ack) next_state = exec_pkg::S_PUSH_LO;
      exec_pkg::S_PUSH_LO:
        if (mem_ack) begin
          if (exec_pkg::sub_field(ir) == exec_pkg::SUB_TRAP)
            next_state = exec_pkg::S_VEC_HI; // RULE5
          else begin
            next_pc = ext[23:0] & exec_pkg::EVEN_MASK; // RULE4
            next_state = ret;
          end
        end
      exec_pkg::S_POP_HI, exec_pkg::S_VEC_HI:
        if (mem_ack) begin
          next_tmp[31:16] = mem_rdata;
          next_state = (state == exec_pkg::S_POP_HI) ?
                       exec_pkg::S_POP_LO : exec_pkg::S_VEC_LO;
        end
      exec_pkg::S_POP_LO:
        if (mem_ack) begin
          next_pc = {tmp[23:16], mem_rdata} & exec_pkg::EVEN_MASK; // RULE4
          next_er[exec_pkg::SP_IDX] = er[exec_pkg::SP_IDX] +
                                      exec_pkg::LONG_STEP;
          if (exec_pkg::sub_field(ir) == exec_pkg::SUB_RTE)
            next_ccr = tmp[31:24]; // RULE6
          next_state = ret;
        end
      exec_pkg::S_VEC_LO:
        if (mem_ack) begin
          next_pc = {tmp[23:16], mem_rdata} & exec_pkg::EVEN_MASK; // RULE5
          next_state = ret;
        end
      exec_pkg::S_CCR_RD:
        if (mem_ack) begin
          next_ccr = mem_rdata[15:8]; // RULE8
          next_state = ret;
        end
      exec_pkg::S_CCR_WR:
        if (mem_ack) next_state = ret;
      exec_pkg::S_MOVE_RD:
        if (mem_ack) begin
          next_tmp[7:0] = mem_rdata[7:0];
          next_state = exec_pkg::S_MOVE_WR;
        end
      exec_pkg::S_MOVE_WR:
        if (mem_ack) begin
          next_er[exec_pkg::SRC_IDX] = er[exec_pkg::SRC_IDX] + 32'h1; // RULE12
          next_er[exec_pkg::DST_IDX] = er[exec_pkg::DST_IDX] + 32'h1;
          if (ir[exec_pkg::MOVE_WIDE])
            next_er[exec_pkg::COUNT_IDX][15:0] = count - 16'h0001; // RULE13
          else
            next_er[exec_pkg::COUNT_IDX][7:0] = count[7:0] - 8'h01;
          next_state = (count == 16'h0001) ? ret :
                       exec_pkg::S_MOVE_RD; // RULE14
        end
      exec_pkg::S_BIT_RD:
        if (mem_ack) begin
          next_tmp[7:0] = bit_mod(mem_rdata[7:0], exec_pkg::sub_field(ir),
                                  exec_pkg::bit_field(ir),
                                  condition_code_reg[exec_pkg::CCR_C]); // RULE20
          next_state = exec_pkg::S_BIT_WR;
        end
      exec_pkg::S_BIT_WR:
        if (mem_ack) next_state = ret;
      exec_pkg::S_SLEEP:
        if (wake | ~run) next_state = ret; // RULE7
      default:
        next_state = exec_pkg::S_HALT;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state <= exec_pkg::S_HALT;
      pc <= exec_pkg::PC_RESET;
      condition_code_reg <= exec_pkg::CCR_RESET;
      ir <= 16'h0000;
      ext <= 32'h00000000;
      tmp <= 32'h00000000;
      run <= 1'b0;
      illegal <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        er[i] <= 32'h00000000;
      end
    end else begin
      state <= next_state;
      pc <= next_pc;
      condition_code_reg <= next_ccr;
      ir <= next_ir;
      ext <= next_ext;
      tmp <= next_tmp;
      run <= next_run;
      illegal <= next_illegal;
      for (int i = 0; i < 8; i++) begin
        er[i] <= next_er[i];
      end
    end
  end
endmodule

// ===== rtl/exec_pkg.sv
// Shared constants, types and field decoders for the instruction executor
package exec_pkg;
  localparam logic [3:0] OP_BCC8   = 4'h4;
  localparam logic [3:0] OP_BCC16  = 4'h3;
  localparam logic [3:0] OP_SYS    = 4'h5;
  localparam logic [3:0] OP_REG8   = 4'h6;
  localparam logic [3:0] OP_BIT    = 4'h7;
  localparam logic [3:0] SUB_JMP_ABS = 4'h0;
  localparam logic [3:0] SUB_JMP_REG = 4'h1;
  localparam logic [3:0] SUB_BSR     = 4'h2;
  localparam logic [3:0] SUB_JSR     = 4'h3;
  localparam logic [3:0] SUB_RTS     = 4'h4;
  localparam logic [3:0] SUB_TRAP    = 4'h5;
  localparam logic [3:0] SUB_RTE     = 4'h6;
  localparam logic [3:0] SUB_SLEEP   = 4'h7;
  localparam logic [3:0] SUB_NOP     = 4'h8;
  localparam logic [3:0] SUB_LDC_IMM = 4'h9;
  localparam logic [3:0] SUB_LDC_MEM = 4'hA;
  localparam logic [3:0] SUB_STC_MEM = 4'hB;
  localparam logic [3:0] SUB_FLAGS_AND_IMM    = 4'hC;
  localparam logic [3:0] SUB_ORC     = 4'hD;
  localparam logic [3:0] SUB_FLAGS_XOR_IMM    = 4'hE;
  localparam logic [3:0] SUB_MOVE    = 4'hF;
  localparam logic [3:0] SUB_LDC_REG = 4'h0;
  localparam logic [3:0] SUB_STC_REG = 4'h1;
  localparam logic [3:0] SUB_BIT_SET_OP    = 4'h0;
  localparam logic [3:0] SUB_BIT_CLEAR_OP    = 4'h1;
  localparam logic [3:0] SUB_BIT_INVERT_OP    = 4'h2;
  localparam logic [3:0] SUB_BST     = 4'h3;
  localparam logic [3:0] SUB_BIT_STORE_INV_CARRY_OP    = 4'h4;
  localparam int CCR_C = 0;
  localparam int CCR_V = 1;
  localparam int CCR_Z = 2;
  localparam int CCR_N = 3;
  localparam int MOVE_WIDE = 7;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_SLEEP = 1;
  localparam int CTRL_ILLEGAL = 2;
  localparam logic [7:0]  OFS_CTRL = 8'h00;
  localparam logic [7:0]  OFS_PC   = 8'h04;
  localparam logic [7:0]  OFS_CCR  = 8'h08;
  localparam logic [7:0]  OFS_IR   = 8'h0C;
  localparam logic [2:0]  OFS_ER_PAGE = 3'h1;
  localparam logic [2:0]  SP_IDX    = 3'h7;
  localparam logic [2:0]  COUNT_IDX = 3'h4;
  localparam logic [2:0]  SRC_IDX   = 3'h5;
  localparam logic [2:0]  DST_IDX   = 3'h6;
  localparam logic [23:0] INSTR_STEP = 24'h000002;
  localparam logic [23:0] HALF_STEP  = 24'h000002;
  localparam logic [31:0] LONG_STEP  = 32'h00000004;
  localparam logic [23:0] EVEN_MASK  = 24'hFFFFFE;
  localparam logic [23:0] TRAP_VEC_BASE = 24'h000020;
  localparam logic [23:0] PC_RESET = 24'h000000;
  localparam logic [7:0]  CCR_RESET = 8'h00;

  typedef enum logic [4:0] {
    S_HALT = 5'h00, S_FETCH = 5'h01, S_EXT_HI = 5'h02, S_EXT_LO = 5'h03,
    S_EXEC = 5'h04, S_PUSH_HI = 5'h05, S_PUSH_LO = 5'h06,
    S_POP_HI = 5'h07, S_POP_LO = 5'h08, S_VEC_HI = 5'h09,
    S_VEC_LO = 5'h0A, S_CCR_RD = 5'h0B, S_CCR_WR = 5'h0C,
    S_MOVE_RD = 5'h0D, S_MOVE_WR = 5'h0E, S_BIT_RD = 5'h0F,
    S_BIT_WR = 5'h10, S_SLEEP = 5'h11
  } state_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        word;
    logic [23:0] addr;
    logic [15:0] wdata;
  } mem_req_t;

  function automatic logic [3:0] op_field(input logic [15:0] w);
    return w[15:12];
  endfunction
  function automatic logic [3:0] sub_field(input logic [15:0] w);
    return w[11:8];
  endfunction
  function automatic logic [2:0] reg_field(input logic [15:0] w);
    return w[6:4];
  endfunction
  function automatic logic [3:0] reg8_field(input logic [15:0] w);
    return w[3:0];
  endfunction
  function automatic logic [2:0] bit_field(input logic [15:0] w);
    return w[2:0];
  endfunction
  function automatic logic [1:0] trap_field(input logic [15:0] w);
    return w[5:4];
  endfunction
  function automatic logic [23:0] sext8(input logic [7:0] d);
    return {{16{d[7]}}, d};
  endfunction
endpackage

// ===== verification/exec_properties.sv
// Checker for the executor's bus and power-down behaviour
module exec_properties (
  input wire logic               clock,           // Clock
  input wire logic               sys_rst,         // Reset
  input wire logic               avs_read,        // Register read
  input wire logic               avs_write,       // Register write
  input wire logic               avs_waitrequest, // Register stall
  input wire exec_pkg::mem_req_t mem_req,         // Memory request
  input wire logic               mem_ack,         // Memory done
  input wire logic               wake,            // Wake request
  input wire logic               sleeping         // Power-down
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  wire busy = mem_req.rd || mem_req.wr;
  sequence byte_rd_done;
    mem_req.rd && !mem_req.word && mem_ack;
  endsequence
  sequence byte_wr_start;
    mem_req.wr && !mem_req.word;
  endsequence
  a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("waitrequest held too long");
  a_idle_ready: assert property (!(avs_read || avs_write)
    |-> !avs_waitrequest) else $error("waitrequest without request");
  a_req_hold: assert property (busy && !mem_ack |=> $stable(mem_req))
    else $error("memory request changed before ack");
  a_one_dir: assert property (!(mem_req.rd && mem_req.wr))
    else $error("read and write together");
  a_word_even: assert property (busy && mem_req.word
    |-> !mem_req.addr[0]) else $error("odd word address");
  a_sleep_quiet: assert property (sleeping |-> !busy)
    else $error("bus activity in power-down");
  a_wake_exit: assert property (sleeping && wake
    |-> ##[1:3] !sleeping) else $error("wake ignored");
  a_byte_rmw: assert property (byte_rd_done
    |-> ##[1:4] byte_wr_start) else $error("byte read not written");
endmodule
bind branch_sysctl_block_move_exec exec_properties chk (.clock, .sys_rst,
  .avs_read, .avs_write, .avs_waitrequest, .mem_req, .mem_ack, .wake,
  .sleeping);

// ===== verification/mem_model.sv
// Byte-wide memory answering the executor's bus requests
module mem_model (
  input  wire logic               clock, // System clock
  input  wire exec_pkg::mem_req_t req,   // Executor request
  input  wire logic               slow,  // Insert wait cycles
  output logic [15:0]             rdata, // Read data
  output logic                    ack    // Access complete
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [4096];
  logic [1:0]  cnt = 2'h0;
  wire  [11:0] a = req.addr[11:0];
  initial ack = 1'h0;
  initial rdata = 16'h0;
  // Stale data inverted each cycle so it never looks valid
  always @(posedge clock) begin
    rdata <= ~rdata;
    ack <= 1'h0;
    cnt <= 2'h0;
    if ((req.rd || req.wr) && !ack) begin
      if (slow && cnt != 2'h2) begin
        cnt <= cnt + 2'h1;
      end else begin
        ack <= 1'h1;
        rdata <= {mem[a], req.word ? mem[a | 12'h1] : mem[a]};
        if (req.wr && req.word) begin
          mem[a] <= req.wdata[15:8];
          mem[a | 12'h1] <= req.wdata[7:0];
        end else if (req.wr) begin
          mem[a] <= req.wdata[7:0];
        end
      end
    end
  end
endmodule

// ===== verification/testbench.sv
// Self-checking bench for the instruction executor
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clock = 1'h0;
  logic               sys_rst = 1'h1;
  logic [7:0]         avs_address = 8'h00;
  logic               avs_read = 1'h0;
  logic               avs_write = 1'h0;
  logic [31:0]        avs_writedata = 32'h0;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  exec_pkg::mem_req_t mem_req;
  logic [15:0]        mem_rdata;
  logic               mem_ack;
  logic               wake = 1'h0;
  logic               sleeping;
  logic               slow = 1'h0;
  logic [31:0]        q;
  logic [3:0]         f;
  int                 failures = 0;
  int                 total_checks = 0;
  logic [15:0] prog [15] = '{16'h5F00, 16'h5A10, 16'h5C3C, 16'h5D81,
    16'h5B00, 16'h7020, 16'h5206, 16'h5000, 16'h0000, 16'h011A,
    16'h5800, 16'h5400, 16'h5E40, 16'h5700, 16'h5700};
  logic [31:0] er [8] = '{32'h300, 32'h310, 32'h320, 32'h0, 32'h203,
    32'h200, 32'h280, 32'h400};
  branch_sysctl_block_move_exec uut (.clock, .sys_rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .mem_req, .mem_rdata, .mem_ack, .wake, .sleeping);
  mem_model ram (.clock, .req(mem_req), .slow, .rdata(mem_rdata),
    .ack(mem_ack));
  initial begin
    forever #5 clock = ~clock;
  end
  task automatic finish_test();
    if (failures == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic tick(inout int n);
    @(posedge clock);
    n++;
    if (n > 3000) begin
      failures++;
      finish_test();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do tick(n); while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge clock);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    check(q, e);
  endtask
  task automatic wait_sleep(input logic lvl);
    int n;
    n = 0;
    while (sleeping !== lvl) tick(n);
  endtask
  // Run to a sleep, wake once into the second sleep, then halt
  task automatic run();
    bus(1'h1, exec_pkg::OFS_PC, 32'h100);
    bus(1'h1, exec_pkg::OFS_CTRL, 32'h1);
    wait_sleep(1'h1);
    wake <= 1'h1;
    @(posedge clock);
    wake <= 1'h0;
    wait_sleep(1'h0);
    wait_sleep(1'h1);
    bus(1'h1, exec_pkg::OFS_CTRL, 32'h0);
    rdchk(exec_pkg::OFS_CTRL, 32'h0);
  endtask
  function automatic void put(input logic [11:0] a, input logic [15:0] v);
    ram.mem[a] = v[15:8];
    ram.mem[a + 12'h1] = v[7:0];
  endfunction
  function automatic logic [31:0] peek(input logic [11:0] a);
    return {ram.mem[a], ram.mem[a + 12'h1], ram.mem[a + 12'h2],
            ram.mem[a + 12'h3]};
  endfunction
  function automatic logic taken(input logic [3:0] c, input logic [3:0] g);
    logic [7:0] s;
    s = {g[2] | (g[3] ^ g[1]), g[3] ^ g[1], g[3], g[1], g[2], g[0],
         g[0] | g[2], 1'h0};
    return s[c[3:1]] == c[0];
  endfunction
  initial begin
    repeat (6) @(posedge clock);
    sys_rst <= 1'h0;
    rdchk(exec_pkg::OFS_PC, 32'h0);
    rdchk(exec_pkg::OFS_CCR, 32'h0);
    rdchk(8'h1C, 32'h0);
    for (int k = 0; k < 32; k++) begin
      f = k[4] ? 4'h9 : 4'h6;
      put(12'h100, {8'h59, 4'h0, f});
      put(12'h102, {4'h4, k[3:0], 8'h02});
      put(12'h104, 16'h5E80);
      put(12'h106, 16'h5700);
      put(12'h108, 16'h5700);
      run();
      rdchk(exec_pkg::OFS_CCR, {24'h0, ~taken(k[3:0], f), 3'h0, f});
    end
    slow <= 1'h1;
    foreach (prog[i]) put(12'h100 + 12'(2 * i), prog[i]);
    foreach (er[i]) bus(1'h1, 8'h20 + 8'(4 * i), er[i]);
    put(12'h200, 16'h1122);
    put(12'h202, 16'h3344);
    put(12'h280, 16'hEEEE);
    put(12'h282, 16'hEEEE);
    put(12'h300, 16'hFFFF);
    put(12'h302, 16'hFFFF);
    put(12'h310, 16'h5AA5);
    put(12'h320, 16'h8000);
    put(12'h322, 16'h0000);
    run();
    check(peek(12'h280), 32'h112233EE);
    rdchk(8'h30, 32'h200);
    rdchk(8'h34, 32'h203);
    rdchk(8'h38, 32'h283);
    rdchk(exec_pkg::OFS_CCR, 32'h99);
    check(peek(12'h300), 32'h9900FFFF);
    check(peek(12'h320), 32'h81000000);
    check(peek(12'h3FC), 32'h0000010E);
    rdchk(8'h3C, 32'h400);
    finish_test();
  end
endmodule
